// ===== src/swc_params.svh
// Constants for the sleep, wake and watchdog controller.
// Assumes inclusion by its bare name from the package and the top module.
`ifndef SWC_PARAMS_SVH
`define SWC_PARAMS_SVH

// Register byte offsets
`define SWC_OFF_CTRL 8'h00
`define SWC_OFF_STATUS 8'h04
`define SWC_OFF_IRQ_STAT 8'h08
`define SWC_OFF_IRQ_MASK 8'h0C
`define SWC_OFF_WDT_KICK 8'h10

// Control register fields
`define SWC_CTRL_SLEEP 0
`define SWC_CTRL_IO_WAKE 1
`define SWC_CTRL_COMM_WAKE 2
`define SWC_CTRL_PULL_OFF 3
`define SWC_CTRL_IO_SEL_LO 4
`define SWC_CTRL_MODE_LO 6
`define SWC_CTRL_IGNORE 8
`define SWC_CTRL_SW_RST 9
`define SWC_CTRL_RST 10'h006

// Interrupt status bits
`define SWC_IRQ_WAKE 0
`define SWC_IRQ_WDT 1
`define SWC_IRQ_SLEPT 2
`define SWC_IRQ_RESUMED 3

// Communication port wake modes
`define SWC_MODE_DIFF 2'h0
`define SWC_MODE_SINGLE 2'h1
`define SWC_MODE_SPECIAL 2'h2

// Clock division and instruction cycle
`define SWC_SYS_DIV 2
`define SWC_SYS_PER_INSTR 3
`define SWC_IN_PER_INSTR (`SWC_SYS_DIV * `SWC_SYS_PER_INSTR)

// Oscillator stabilisation, in input clock transitions
`define SWC_STAB_TRANS 15
`define SWC_STAB_CYCLES ((`SWC_STAB_TRANS + 1) / 2)

// Maintenance after wake, in input clock cycles
`define SWC_MAINT_TYP_NOIGN 2000
`define SWC_MAINT_WORST_NOIGN 47000
`define SWC_MAINT_TYP_IGN 7200
`define SWC_MAINT_WORST_IGN 66000

// Watchdog period: time in ms at the reference input rate
`define SWC_WDT_TIME_MS 840
`define SWC_WDT_REF_MHZ 10
`define SWC_WDT_CYCLES (`SWC_WDT_TIME_MS * 1000 * `SWC_WDT_REF_MHZ)

`endif

// ===== src/swc_pkg.sv
// Types shared by the sleep, wake and watchdog controller.
// Assumes the constants header is on the include path.
`include "swc_params.svh"
package swc_pkg;

  // Controller sequence, one-hot
  typedef enum logic [5:0] {
    SWC_RUN   = 6'h01,
    SWC_DRAIN = 6'h02,
    SWC_SLEEP = 6'h04,
    SWC_OSC   = 6'h08,
    SWC_STAB  = 6'h10,
    SWC_MAINT = 6'h20
  } swc_state_e;

  // Drive state of port pins and service pin
  typedef struct packed {
    logic [10:0] port_out;
    logic [10:0] port_oe;
    logic svc_out;
    logic svc_oe;
  } swc_pins_s;

  // Control register layout
  typedef struct packed {
    logic sw_rst;
    logic comm_ignore;
    logic [1:0] comm_mode;
    logic [1:0] io_sel;
    logic pull_off;
    logic comm_wake_en;
    logic io_wake_en;
    logic sleep_req;
  } swc_ctrl_s;

endpackage

// ===== src/swc_top.sv
// Sleep/wake sequencer, clock division and three watchdogs.
// Assumes sys_clk is the input clock and pins arrive unsynchronised.
//
// Overview of operation
// - System clock is input clock halved
// - Instruction cycle is six input clocks
// - Sleep stops system clock and timers
// - Selected upper port pin wakes, maskable
// - Service pin transition always wakes
// - Mode-selected comm line wakes, maskable
// - Optional pull-up disable during sleep
// - Pins hold pre-sleep levels while asleep
// - Sleep waits for packet transmission end
// - Memory enable held high while asleep
// - Restart oscillator, stabilise, maintain, resume
// - Maintenance 2000 or 47000 cycles
// - Ignore option: 7200 or 66000 cycles
// - Three watchdogs, expiry resets chip
// - Watchdog period 0.84 s at 10 MHz
// - Watchdogs disabled during sleep
// - Pull reset pin until sensed low
`include "swc_params.svh"
module swc_top #(
  parameter int WDT_CYCLES = `SWC_WDT_CYCLES,
  parameter int MAINT_WORST_NOIGN = `SWC_MAINT_WORST_NOIGN,
  parameter int MAINT_TYP_IGN = `SWC_MAINT_TYP_IGN,
  parameter int MAINT_WORST_IGN = `SWC_MAINT_WORST_IGN
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // Wake pins, raw
  input wire logic [3:0] upper_port_pins,
  input wire logic service_pin_in,
  input wire logic comm_line_zero,
  input wire logic comm_line_one,
  input wire logic comm_line_three,
  // Oscillator
  input wire logic osc_running,
  output logic osc_enable,
  // Core side
  input wire logic tx_busy,
  input wire logic maint_worst,
  input wire logic mem_e_n_core,
  input wire swc_pkg::swc_pins_s core_pins,
  // Pin drive
  output swc_pkg::swc_pins_s held_pins,
  output logic mem_e_n,
  output logic [4:0] pullup_en,
  // Clocks out
  output logic sys_clk_half,
  output logic instr_strobe,
  output logic timer_run,
  // Reset pin, open drain
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe
);
  import swc_pkg::*;

  localparam int NSYNC = 10;
  localparam logic [2:0] STAB_LAST = 3'(`SWC_STAB_CYCLES - 1);

  // Register address match, used by read and write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Synchroniser stages
  logic [NSYNC-1:0] raw_w;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  // Wake line reference at sleep entry
  logic [NSYNC-1:0] ref_q;
  // Sequencer
  swc_state_e state_q;
  logic sleep_pend_q;
  logic [2:0] stab_q;
  logic [16:0] maint_q;
  logic [16:0] maint_len_w;
  // Registers
  swc_ctrl_s ctrl_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic [3:0] irq_set_w;
  // Latched wake enables and pull-up option
  logic io_en_q;
  logic comm_en_q;
  logic pull_off_q;
  // Clock generation
  logic [2:0] phase_q;
  // Watchdogs
  logic [23:0] wdt_q [3];
  logic [2:0] wdt_exp_w;
  logic [2:0] kick_w;
  // Decoded events
  logic wr_ctrl_w;
  logic wake_io_w;
  logic wake_svc_w;
  logic wake_comm_w;
  logic wake_w;
  logic asleep_w;
  logic frozen_w;
  logic reset_req_w;

  // Raw pin vector; index 9 is reset pin, 8 oscillator good
  assign raw_w = {reset_pin_in, osc_running, comm_line_three,
                  comm_line_one, comm_line_zero, service_pin_in,
                  upper_port_pins};

  // Two-stage synchronisers, first stage read only by second
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= raw_w[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  // Decodes
  assign wr_ctrl_w = reg_wr && hit(reg_addr, `SWC_OFF_CTRL);
  assign kick_w = (reg_wr && hit(reg_addr, `SWC_OFF_WDT_KICK)) ?
                  reg_wdata[2:0] : 3'h0;
  assign asleep_w = (state_q == SWC_SLEEP);
  // Pins stay frozen until maintenance, since the core is not yet up
  assign frozen_w = (state_q == SWC_SLEEP) || (state_q == SWC_OSC) ||
                    (state_q == SWC_STAB);

  // Wake sources compared against the level seen at sleep entry
  always_comb begin
    wake_io_w = io_en_q &&
      (sync_q[ctrl_q.io_sel] != ref_q[ctrl_q.io_sel]);
    wake_svc_w = (sync_q[4] != ref_q[4]);
    unique case (ctrl_q.comm_mode)
      `SWC_MODE_DIFF: wake_comm_w = (sync_q[5] != ref_q[5]) ||
                                    (sync_q[6] != ref_q[6]);
      `SWC_MODE_SINGLE: wake_comm_w = (sync_q[5] != ref_q[5]);
      `SWC_MODE_SPECIAL: wake_comm_w = (sync_q[7] != ref_q[7]);
      default: wake_comm_w = 1'b0;
    endcase
    wake_comm_w = wake_comm_w && comm_en_q;
    wake_w = asleep_w && (wake_io_w || wake_svc_w || wake_comm_w);
  end

  // Maintenance length from ignore option and load
  always_comb begin
    if (ctrl_q.comm_ignore) begin
      maint_len_w = maint_worst ? 17'(MAINT_WORST_IGN) :
                                  17'(MAINT_TYP_IGN);
    end else begin
      maint_len_w = maint_worst ? 17'(MAINT_WORST_NOIGN) :
                                  17'(`SWC_MAINT_TYP_NOIGN);
    end
  end

  // Sleep request is remembered until the sequencer takes it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sleep_pend_q <= 1'b0;
    end else if (wr_ctrl_w && reg_wdata[`SWC_CTRL_SLEEP]) begin
      sleep_pend_q <= 1'b1;
    end else if (state_q != SWC_RUN) begin
      sleep_pend_q <= 1'b0;
    end
  end

  // Main sleep and wake sequence
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= SWC_RUN;
      stab_q <= 3'h0;
      maint_q <= 17'h00000;
    end else begin
      unique case (state_q)
        SWC_RUN: begin
          if (sleep_pend_q) begin
            state_q <= SWC_DRAIN;
          end
        end
        SWC_DRAIN: begin
          // Never cut a packet short
          if (!tx_busy) begin
            state_q <= SWC_SLEEP;
          end
        end
        SWC_SLEEP: begin
          if (wake_w) begin
            state_q <= SWC_OSC;
          end
        end
        SWC_OSC: begin
          // Oscillator start-up time depends on the resonator
          if (sync_q[8]) begin
            state_q <= SWC_STAB;
            stab_q <= 3'h0;
          end
        end
        SWC_STAB: begin
          if (stab_q == STAB_LAST) begin
            state_q <= SWC_MAINT;
            maint_q <= maint_len_w - 17'h00001;
          end else begin
            stab_q <= stab_q + 3'h1;
          end
        end
        SWC_MAINT: begin
          if (maint_q == 17'h00000) begin
            state_q <= SWC_RUN;
          end else begin
            maint_q <= maint_q - 17'h00001;
          end
        end
      endcase
    end
  end

  // Capture wake references and enables on entering sleep
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ref_q <= '0;
      io_en_q <= 1'b0;
      comm_en_q <= 1'b0;
      pull_off_q <= 1'b0;
    end else if (state_q == SWC_DRAIN && !tx_busy) begin
      ref_q <= sync_q;
      io_en_q <= ctrl_q.io_wake_en;
      comm_en_q <= ctrl_q.comm_wake_en;
      pull_off_q <= ctrl_q.pull_off;
    end
  end

  // Control register; strobe bits never stay set
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_q <= swc_ctrl_s'(`SWC_CTRL_RST);
    end else if (wr_ctrl_w) begin
      ctrl_q <= swc_ctrl_s'(reg_wdata[9:0]);
    end else begin
      ctrl_q.sleep_req <= 1'b0;
      ctrl_q.sw_rst <= 1'b0;
    end
  end

  // Clock divider and instruction phase halt in sleep
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sys_clk_half <= 1'b0;
      phase_q <= 3'h0;
      instr_strobe <= 1'b0;
      timer_run <= 1'b0;
    end else if (asleep_w) begin
      instr_strobe <= 1'b0;
      timer_run <= 1'b0;
    end else begin
      sys_clk_half <= ~sys_clk_half;
      timer_run <= 1'b1;
      if (phase_q == 3'(`SWC_IN_PER_INSTR - 1)) begin
        phase_q <= 3'h0;
        instr_strobe <= 1'b1;
      end else begin
        phase_q <= phase_q + 3'h1;
        instr_strobe <= 1'b0;
      end
    end
  end

  // Three watchdogs, each reloaded by its own restart bit
  generate
    for (gi = 0; gi < 3; gi++) begin : g_wdt
      assign wdt_exp_w[gi] = (wdt_q[gi] == 24'h000000) && !asleep_w;
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          wdt_q[gi] <= 24'(WDT_CYCLES - 1);
        end else if (kick_w[gi] || wdt_exp_w[gi]) begin
          wdt_q[gi] <= 24'(WDT_CYCLES - 1);
        end else if (!asleep_w) begin
          // Counted in input cycles so the period scales with rate
          wdt_q[gi] <= wdt_q[gi] - 24'h000001;
        end
      end
    end
  endgenerate

  // Reset request from any watchdog or from software
  assign reset_req_w = (|wdt_exp_w) || ctrl_q.sw_rst;

  // Drive reset pin low until it reads back low
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reset_pin_oe <= 1'b0;
      reset_pin_out <= 1'b0;
    end else if (reset_req_w) begin
      reset_pin_oe <= 1'b1;
    end else if (reset_pin_oe && !sync_q[9]) begin
      // External capacitor then stretches the pulse
      reset_pin_oe <= 1'b0;
    end
  end

  // Pins hold their level while asleep
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      held_pins <= '0;
    end else if (!frozen_w) begin
      held_pins <= core_pins;
    end
  end

  // Memory strobe parked inactive, pull-ups optionally off
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mem_e_n <= 1'b1;
      pullup_en <= 5'h1F;
      osc_enable <= 1'b1;
    end else begin
      mem_e_n <= frozen_w ? 1'b1 : mem_e_n_core;
      pullup_en <= (asleep_w && pull_off_q) ? 5'h00 : 5'h1F;
      osc_enable <= !asleep_w;
    end
  end

  // Interrupt events
  assign irq_set_w[`SWC_IRQ_WAKE] = wake_w;
  assign irq_set_w[`SWC_IRQ_WDT] = |wdt_exp_w;
  assign irq_set_w[`SWC_IRQ_SLEPT] = (state_q == SWC_DRAIN) && !tx_busy;
  assign irq_set_w[`SWC_IRQ_RESUMED] = (state_q == SWC_MAINT) &&
                                       (maint_q == 17'h00000);

  // Sticky status, write one clears, set beats clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_stat_q <= 4'h0;
    end else if (reg_wr && hit(reg_addr, `SWC_OFF_IRQ_STAT)) begin
      irq_stat_q <= (irq_stat_q & ~reg_wdata[3:0]) | irq_set_w;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set_w;
    end
  end

  // Interrupt mask
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_mask_q <= 4'h0;
    end else if (reg_wr && hit(reg_addr, `SWC_OFF_IRQ_MASK)) begin
      irq_mask_q <= reg_wdata[3:0];
    end
  end

  // Level interrupt output
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_stat_q | irq_set_w) & irq_mask_q);
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else if (hit(reg_addr, `SWC_OFF_CTRL)) begin
      reg_rdata <= {22'h000000, ctrl_q.sw_rst & 1'b0, ctrl_q.comm_ignore,
                    ctrl_q.comm_mode, ctrl_q.io_sel, ctrl_q.pull_off,
                    ctrl_q.comm_wake_en, ctrl_q.io_wake_en, 1'b0};
    end else if (hit(reg_addr, `SWC_OFF_STATUS)) begin
      reg_rdata <= {22'h000000, reset_pin_oe, sleep_pend_q, tx_busy,
                    asleep_w, state_q};
    end else if (hit(reg_addr, `SWC_OFF_IRQ_STAT)) begin
      reg_rdata <= {28'h0000000, irq_stat_q};
    end else if (hit(reg_addr, `SWC_OFF_IRQ_MASK)) begin
      reg_rdata <= {28'h0000000, irq_mask_q};
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // swc_top

// ===== tb/swc_top_chk.sv
// Port checker for the sleep, wake and watchdog controller.
// Assumes it is bound onto swc_top; one clock, sync reset.
module swc_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic irq,
  // Sleep side
  input wire logic osc_enable,
  input wire logic mem_e_n,
  input wire swc_pkg::swc_pins_s held_pins,
  input wire logic [4:0] pullup_en,
  // Derived clocks
  input wire logic sys_clk_half,
  input wire logic instr_strobe,
  input wire logic timer_run,
  // Reset pin
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import swc_pkg::*;
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // High from the second edge after reset, so $past is trustworthy
  logic up_q;

  // Track reset release
  always_ff @(posedge sys_clk) begin
    up_q <= !sys_rst;
  end

  half_toggle_a:
  assert property (up_q && timer_run && $past(timer_run)
    |-> sys_clk_half != $past(sys_clk_half))
    else $error("system clock did not toggle");
  instr_gap_a:
  assert property (instr_strobe |=> !instr_strobe [*5])
    else $error("instruction strobe too early");
  instr_period_a:
  assert property (instr_strobe ##1 timer_run [*6] |-> instr_strobe)
    else $error("instruction strobe missing");
  mem_park_a:
  assert property (!osc_enable |-> mem_e_n && !timer_run)
    else $error("memory strobe or timers active asleep");
  pin_hold_a:
  assert property (!osc_enable |-> $stable(held_pins))
    else $error("pins moved while asleep");
  pull_awake_a:
  assert property (osc_enable |-> pullup_en == 5'h1F)
    else $error("pull-ups off while awake");
  stab_wait_a:
  assert property ($rose(osc_enable) |-> mem_e_n [*8])
    else $error("memory used before oscillator settled");
  wdt_asleep_a:
  assert property (!osc_enable |=> !$rose(reset_pin_oe))
    else $error("watchdog fired while asleep");
  rst_pull_a:
  assert property ($rose(reset_pin_oe)
    |-> (reset_pin_oe && !reset_pin_out) [*2])
    else $error("reset pin released before sensed");
  rst_release_a:
  assert property (reset_pin_oe && !reset_pin_in |-> ##[1:4] !reset_pin_oe)
    else $error("reset pin never released");
  rdata_idle_a:
  assert property (up_q && !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  irq_mask_a:
  assert property (reg_wr && reg_addr == 8'h0C && reg_wdata[3:0] == 4'h0
    |=> ##1 !irq)
    else $error("interrupt ignores mask");

  // Main scenarios reached
  slept_c: cover property ($fell(osc_enable));
  woke_c: cover property ($rose(osc_enable));
  wdt_c: cover property ($rose(reset_pin_oe));
  irq_c: cover property ($rose(irq));
endmodule // swc_chk

bind swc_top swc_chk u_chk (.sys_clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .irq, .osc_enable, .mem_e_n, .held_pins,
  .pullup_en, .sys_clk_half, .instr_strobe, .timer_run, .reset_pin_in,
  .reset_pin_out, .reset_pin_oe);

// ===== tb/swc_top_tb.sv
// Testbench for the sleep, wake and watchdog controller.
// Assumes the package and constants header compile first.
`include "swc_params.svh"
module swc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import swc_pkg::*;

  // Clock, reset and register port
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq;
  // Wake pins: upper nibble, service, comm 0, 1, 3
  logic [7:0] wk = 8'h00;
  // Core side and oscillator model
  logic osc_running = 1'b0;
  logic osc_enable;
  logic tx_busy = 1'b0;
  logic maint_worst = 1'b0;
  swc_pins_s core_pins = '0;
  swc_pins_s held_pins;
  logic mem_e_n;
  logic [4:0] pullup_en;
  logic sys_clk_half;
  logic instr_strobe;
  logic timer_run;
  logic reset_pin_out;
  logic reset_pin_oe;
  // Open-drain reset wire with pull-up
  wire logic reset_pin_in = !(reset_pin_oe && !reset_pin_out);
  int miscompares = 0;
  int num_checks = 0;

  // 50 MHz input clock
  always #10 sys_clk = ~sys_clk;

  // Oscillator starts one cycle after it is enabled
  always @(posedge sys_clk) begin
    osc_running <= osc_enable;
  end

  // Short counts keep the run brief
  swc_top #(.WDT_CYCLES(2500), .MAINT_WORST_NOIGN(30),
    .MAINT_TYP_IGN(40), .MAINT_WORST_IGN(50)) u_swc_top (
    .sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq, .upper_port_pins(wk[3:0]), .service_pin_in(wk[4]),
    .comm_line_zero(wk[5]), .comm_line_one(wk[6]),
    .comm_line_three(wk[7]), .osc_running, .osc_enable, .tx_busy,
    .maint_worst, .mem_e_n_core(1'b0), .core_pins, .held_pins, .mem_e_n,
    .pullup_en, .sys_clk_half, .instr_strobe, .timer_run, .reset_pin_in,
    .reset_pin_out, .reset_pin_oe);

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read; data stands only in the next cycle
  task automatic rc(logic [7:0] a, logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, e);
  endtask

  // Bounded wait for an output level; n is cycles taken
  task automatic wt(int s, logic v, int lim, output int n);
    logic x;
    n = 0;
    do begin
      @(negedge sys_clk);
      case (s)
        0: x = osc_enable;
        1: x = irq;
        2: x = reset_pin_oe;
        default: x = mem_e_n;
      endcase
      n++;
    end while (x !== v && n < lim);
    if (x !== v) begin
      miscompares++;
      report_and_stop();
    end
  endtask

  // Sleep, poke a pin that must not wake, then one that must
  task automatic nap(logic [9:0] c, int no, int yes, logic w, int len,
    int m);
    int n;
    wr(8'h10, 32'h7);
    core_pins <= 24'hA5A5A5;
    wr(8'h00, {22'h0, c | 10'h001});
    if (tx_busy) begin
      repeat (8) @(negedge sys_clk);
      chk(osc_enable, 1'b1);
      @(posedge sys_clk);
      tx_busy <= 1'b0;
    end
    wt(0, 1'b0, 20, n);
    @(posedge sys_clk);
    core_pins <= 24'h5A5A5A;
    maint_worst <= w;
    repeat (3) @(negedge sys_clk);
    chk(held_pins, 24'hA5A5A5);
    chk({timer_run, mem_e_n}, 2'b01);
    chk(pullup_en, c[3] ? 5'h00 : 5'h1F);
    @(posedge sys_clk);
    wk[no] <= !wk[no];
    repeat (len) @(negedge sys_clk);
    chk(osc_enable, 1'b0);
    chk(reset_pin_oe, 1'b0);
    @(posedge sys_clk);
    wk[yes] <= !wk[yes];
    wt(0, 1'b1, 8, n);
    wt(3, 1'b0, 40, n);
    wt(1, 1'b1, 2100, n);
    chk(n >= m - 2 && n <= m + 3, 1'b1);
    rc(8'h08, 32'hD);
    wr(8'h08, 32'hF);
    wt(1, 1'b0, 4, n);
  endtask

  // Main sequence
  initial begin
    int n;
    int k;
    logic b;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rc(8'h00, 32'h6);
    rc(8'h04, 32'h1);
    rc(8'h20, 32'h0);
    rc(8'h10, 32'h0);
    wr(8'h0C, 32'h0);
    wr(8'h0C, 32'h8);
    rc(8'h0C, 32'h8);
    chk({mem_e_n, pullup_en}, 6'h1F);
    // Divider toggles; one strobe per six input clocks
    k = 0;
    for (int i = 0; i < 60; i++) begin
      b = sys_clk_half;
      @(negedge sys_clk);
      chk(sys_clk_half, !b);
      k += instr_strobe;
    end
    chk(k, 10);
    // Sleep held off by a packet, then the wake sources
    @(posedge sys_clk);
    tx_busy <= 1'b1;
    nap(10'h026, 1, 2, 1'b1, 10, 30);
    nap(10'h136, 7, 6, 1'b0, 10, 40);
    nap(10'h176, 6, 5, 1'b1, 10, 50);
    nap(10'h0B6, 5, 7, 1'b0, 10, `SWC_MAINT_TYP_NOIGN);
    nap(10'h008, 0, 4, 1'b1, 2600, 30);
    nap(10'h00A, 5, 0, 1'b1, 10, 30);
    // Kicking two watchdogs leaves the third to expire
    wr(8'h10, 32'h7);
    repeat (1200) @(posedge sys_clk);
    wr(8'h10, 32'h3);
    wt(2, 1'b1, 1400, n);
    chk(n >= 1293 && n <= 1303, 1'b1);
    chk(reset_pin_out, 1'b0);
    wt(2, 1'b0, 8, n);
    rc(8'h08, 32'h2);
    // Software reset pulls the pin too
    wr(8'h00, 32'h20E);
    wt(2, 1'b1, 4, n);
    wt(2, 1'b0, 8, n);
    // Chip reset again in mid-run
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rc(8'h00, 32'h6);
    rc(8'h08, 32'h0);
    report_and_stop();
  end
endmodule // swc_top_tb
